// [event_flag_interrupt_unit.sv]
// Purpose: Latched event flags, interrupt mask, live status and interrupt pin.
// Assumes: Register port and event levels run on clk; no synchronisers needed.
// Notes:   Read data appears one cycle after the read strobe.
//
// Notes on behaviour
// - Enabled mask bit routes its flag to interrupt unless sample enable is set.
// - Sample enable gives interrupt per new sample.
// - Mask resets with only reset-complete enabled.
// - Flags reset clear and hold until acknowledged.
// - Writing one clears a flag; zero keeps.
// - Flag clears work while registers are locked.
// - Warning flags latch on comparator rising edges.
// - Output flags latch on channel output rises.
// - Cool-down flags latch on cool-down entry.
// - Thermal flag latches on load thermal shutdown.
// - Link fault flag latches; retransmission elsewhere.
// - Mismatch flag latches on register copy disagreement.
// - Reset-complete and busy flags latch too.
// - Live register shows unlatched present conditions.
// - Live reset bit follows its level; top bit zero.
// - Samples at 100 kHz alternating both channels.
`timescale 1ns/10ps
module event_flag_interrupt_unit #(
   parameter int SAMPLE_PERIOD = event_irq_pkg::SAMPLE_CYCLES
) (
   input  wire logic                                  clk,
   input  wire logic                                  rstn,
   input  wire logic                                  reg_lock,
   input  wire logic [event_irq_pkg::ADDR_W-1:0]      reg_addr,
   input  wire logic                                  reg_wr,
   input  wire logic                                  reg_rd,
   input  wire logic [event_irq_pkg::REG_W-1:0]       reg_wdata,
   input  wire logic [event_irq_pkg::EVENT_W-1:0]     event_level,
   output logic      [event_irq_pkg::REG_W-1:0]       reg_rdata,
   output logic                                       reg_rvalid,
   output logic                                       irq_n,
   output logic                                       sample_strobe,
   output logic                                       sample_chan
);
   import event_irq_pkg::*;

   localparam int PULSE_LEN = SAMPLE_IRQ_CYCLES;

   // ==========================================================================
   // Submodules
   event_path_if ev ();

   assign ev.level = event_level;

   rise_detector u_rise (
      .clk  (clk),
      .rstn (rstn),
      .ev   (ev.detect)
   );

   sample_pacer #(
      .PERIOD (SAMPLE_PERIOD)
   ) u_pacer (
      .clk  (clk),
      .rstn (rstn),
      .ev   (ev.pace)
   );

   // ==========================================================================
   // Register decode
   logic mask_wr;
   logic flag_clr_wr;

   // Selects the register hit by a write; the lock only guards the mask.
   always_comb begin
      mask_wr     = reg_wr && (reg_addr == MASK_OFFSET) && !reg_lock;
      flag_clr_wr = reg_wr && (reg_addr == LATCHED_OFFSET);
   end

   // ==========================================================================
   // Mask and latched flags
   logic [REG_W-1:0]   mask_q, mask_d;
   logic [EVENT_W-1:0] flags_q, flags_d;

   // Stores the mask and sets or clears flags; a new event beats a clear.
   always_comb begin
      mask_d  = mask_q;
      flags_d = flags_q;
      if (mask_wr) begin
         mask_d = reg_wdata;
      end
      if (flag_clr_wr) begin
         flags_d = flags_d & ~reg_wdata[EVENT_W-1:0];
      end
      // Every source bit latches on its own rising edge.
      flags_d = flags_d | ev.rise;
   end

   // Registers the mask and flags.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_q  <= MASK_RESET;
         flags_q <= LATCHED_RESET[EVENT_W-1:0];
      end else begin
         mask_q  <= mask_d;
         flags_q <= flags_d;
      end
   end

   // ==========================================================================
   // Interrupt pin
   logic [PULSE_W-1:0] pulse_q, pulse_d;
   logic               irq_n_q, irq_n_d;
   logic               flag_hit;

   // In sample mode each tick opens a fixed pulse; otherwise enabled flags drive it.
   always_comb begin
      pulse_d  = '0;
      flag_hit = |(flags_q & mask_q[EVENT_W-1:0]);
      if (mask_q[BIT_SAMPLE_EN]) begin
         if (ev.sample_tick) begin
            pulse_d = PULSE_W'(SAMPLE_IRQ_CYCLES);
         end else if (pulse_q != '0) begin
            pulse_d = pulse_q - 1'b1;
         end
      end
      // Sample mode takes the pin over; the host keeps other mask bits clear.
      if (mask_q[BIT_SAMPLE_EN]) begin
         irq_n_d = (pulse_d == '0);
      end else begin
         irq_n_d = !flag_hit;
      end
   end

   // Registers the pulse timer and the pin.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pulse_q <= '0;
         irq_n_q <= 1'b1;
      end else begin
         pulse_q <= pulse_d;
         irq_n_q <= irq_n_d;
      end
   end

   // ==========================================================================
   // Read port
   logic [REG_W-1:0] rdata_q, rdata_d;
   logic             rvalid_q, rvalid_d;
   logic             strobe_q, chan_q;

   // Returns mask, latched flags or the live levels; unmapped reads give zero.
   always_comb begin
      rdata_d  = READ_IDLE;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         unique case (reg_addr)
            MASK_OFFSET:    rdata_d = mask_q;
            LATCHED_OFFSET: rdata_d = {1'b0, flags_q};
            LIVE_OFFSET:    rdata_d = {1'b0, event_level};
            default:        rdata_d = READ_IDLE;
         endcase
      end
   end

   // Registers read data and the sample outputs.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q  <= READ_IDLE;
         rvalid_q <= 1'b0;
         strobe_q <= 1'b0;
         chan_q   <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         strobe_q <= ev.sample_tick;
         chan_q   <= ev.sample_chan;
      end
   end

   assign reg_rdata     = rdata_q;
   assign reg_rvalid    = rvalid_q;
   assign irq_n         = irq_n_q;
   assign sample_strobe = strobe_q;
   assign sample_chan   = chan_q;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_mask_reset;
      $rose(rstn) |-> (mask_q == MASK_RESET) && (flags_q == '0);
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("Mask or flags wrong after reset.");

   property p_flag_sets;
      (ev.rise != '0) |=> ((flags_q & $past(ev.rise)) == $past(ev.rise));
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("Event edge not latched.");

   property p_flag_holds;
      !flag_clr_wr ##0 (flags_q != '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("Flag lost without a clear.");

   property p_flag_clears;
      flag_clr_wr |=> ((flags_q & $past(reg_wdata[EVENT_W-1:0]) & ~$past(ev.rise)) == '0);
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("Write of one did not clear.");

   property p_clear_locked;
      reg_lock && reg_wr && (reg_addr == LATCHED_OFFSET) && (ev.rise == '0)
         |=> (flags_q == ($past(flags_q) & ~$past(reg_wdata[EVENT_W-1:0])));
   endproperty
   a_clear_locked: assert property (p_clear_locked) else $error("Clear refused under lock.");

   property p_irq_asserts;
      !mask_q[BIT_SAMPLE_EN] && ((flags_q & mask_q[EVENT_W-1:0]) != '0) |=> !irq_n;
   endproperty
   a_irq_asserts: assert property (p_irq_asserts) else $error("Enabled flag gave no interrupt.");

   property p_irq_releases;
      !mask_q[BIT_SAMPLE_EN] && ((flags_q & mask_q[EVENT_W-1:0]) == '0) |=> irq_n;
   endproperty
   a_irq_releases: assert property (p_irq_releases) else $error("Interrupt held with nothing enabled.");

   property p_sample_irq;
      mask_q[BIT_SAMPLE_EN] && ev.sample_tick |=> !irq_n ##PULSE_LEN irq_n;
   endproperty
   a_sample_irq: assert property (p_sample_irq) else $error("Sample interrupt pulse wrong.");

   property p_live_read;
      reg_rd && (reg_addr == LIVE_OFFSET) |=> reg_rvalid && (reg_rdata == {1'b0, $past(event_level)});
   endproperty
   a_live_read: assert property (p_live_read) else $error("Live status readback wrong.");

   property p_live_top;
      reg_rd && (reg_addr == LIVE_OFFSET) |=> !reg_rdata[BIT_SAMPLE_EN]
         && (reg_rdata[BIT_RESET_DONE] == $past(event_level[BIT_RESET_DONE]));
   endproperty
   a_live_top: assert property (p_live_top) else $error("Live top bits wrong.");

   // Each source group but link busy, followed from its level edge through the detector to its latched flag.
   property p_output_latch;
      $rose(event_level[BIT_CH2_DOUT]) |-> ##2 flags_q[BIT_CH2_DOUT];
   endproperty
   a_output_latch: assert property (p_output_latch) else $error("Output edge not latched.");

   property p_warn_latch;
      $rose(event_level[BIT_CH2_WARN_B]) |-> ##2 flags_q[BIT_CH2_WARN_B];
   endproperty
   a_warn_latch: assert property (p_warn_latch) else $error("Warning edge not latched.");

   property p_cool_latch;
      $rose(event_level[BIT_CH2_COOL_DOWN]) |-> ##2 flags_q[BIT_CH2_COOL_DOWN];
   endproperty
   a_cool_latch: assert property (p_cool_latch) else $error("Cool-down entry not latched.");

   property p_thermal_latch;
      $rose(event_level[BIT_THERMAL]) |-> ##2 flags_q[BIT_THERMAL];
   endproperty
   a_thermal_latch: assert property (p_thermal_latch) else $error("Thermal shutdown not latched.");

   property p_link_latch;
      $rose(event_level[BIT_LINK_FAULT]) |-> ##2 flags_q[BIT_LINK_FAULT];
   endproperty
   a_link_latch: assert property (p_link_latch) else $error("Link fault not latched.");

   property p_mismatch_latch;
      $rose(event_level[BIT_MISMATCH]) |-> ##2 flags_q[BIT_MISMATCH];
   endproperty
   a_mismatch_latch: assert property (p_mismatch_latch) else $error("Mismatch not latched.");

   property p_done_latch;
      $rose(event_level[BIT_RESET_DONE]) |-> ##2 flags_q[BIT_RESET_DONE];
   endproperty
   a_done_latch: assert property (p_done_latch) else $error("Reset completion not latched.");

   // Mask writes land unless the lock is set; a locked write leaves the mask alone.
   property p_mask_write;
      mask_wr |=> (mask_q == $past(reg_wdata));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("Mask write did not land.");

   property p_mask_locked;
      reg_lock && reg_wr && (reg_addr == MASK_OFFSET) |=> $stable(mask_q);
   endproperty
   a_mask_locked: assert property (p_mask_locked) else $error("Locked mask write took effect.");

   // In sample mode the pin rests high between pulses, whatever the flags hold.
   property p_sample_quiet;
      mask_q[BIT_SAMPLE_EN] && !ev.sample_tick && (pulse_q <= PULSE_W'(1)) |=> irq_n;
   endproperty
   a_sample_quiet: assert property (p_sample_quiet) else $error("Pin low between pulses.");

   // The strobe and channel outputs trail the internal tick by one cycle.
   property p_strobe_follows;
      ev.sample_tick |=> sample_strobe && (sample_chan == $past(ev.sample_chan));
   endproperty
   a_strobe_follows: assert property (p_strobe_follows) else $error("Sample strobe or channel wrong.");

   c_flag_irq: cover property (!mask_q[BIT_SAMPLE_EN] && $fell(irq_n));
   c_sample_irq: cover property (mask_q[BIT_SAMPLE_EN] && ev.sample_tick ##1 !irq_n);
   c_set_beats_clear: cover property (flag_clr_wr && ((reg_wdata[EVENT_W-1:0] & ev.rise) != '0));
   c_locked_clear: cover property (reg_lock && flag_clr_wr);
   c_locked_mask: cover property (reg_lock && reg_wr && (reg_addr == MASK_OFFSET));
endmodule

// [event_irq_pkg.sv]
// Purpose: Shared constants for the event flag and interrupt unit.
// Assumes: 20 MHz core clock; register port addressed by word offset.
// Notes:   Bit positions apply to the mask, latched and live registers alike.
package event_irq_pkg;

   // ==========================================================================
   // Register map
   localparam int          ADDR_W         = 10;
   localparam int          REG_W          = 16;
   localparam int          EVENT_W        = 15;
   localparam logic [9:0]  MASK_OFFSET    = 10'h00b;
   localparam logic [9:0]  LATCHED_OFFSET = 10'h00c;
   localparam logic [9:0]  LIVE_OFFSET    = 10'h00d;
   localparam logic [15:0] MASK_RESET     = 16'h4000;
   localparam logic [15:0] LATCHED_RESET  = 16'h0000;
   localparam logic [15:0] READ_IDLE      = 16'h0000;

   // ==========================================================================
   // Field positions
   localparam int BIT_CH1_DOUT      = 0;
   localparam int BIT_CH1_WARN_A    = 1;
   localparam int BIT_CH1_WARN_B    = 2;
   localparam int BIT_CH1_WARN_C    = 3;
   localparam int BIT_CH2_DOUT      = 4;
   localparam int BIT_CH2_WARN_A    = 5;
   localparam int BIT_CH2_WARN_B    = 6;
   localparam int BIT_CH2_WARN_C    = 7;
   localparam int BIT_MISMATCH      = 8;
   localparam int BIT_LINK_FAULT    = 9;
   localparam int BIT_THERMAL       = 10;
   localparam int BIT_CH1_COOL_DOWN = 11;
   localparam int BIT_CH2_COOL_DOWN = 12;
   localparam int BIT_LINK_BUSY     = 13;
   localparam int BIT_RESET_DONE    = 14;
   localparam int BIT_SAMPLE_EN     = 15;

   // ==========================================================================
   // Timing
   localparam int CLK_HZ             = 20_000_000;
   localparam int CLK_PERIOD_NS      = 50;
   localparam int SAMPLE_RATE_HZ     = 100_000;
   localparam int SAMPLE_CYCLES      = CLK_HZ / SAMPLE_RATE_HZ;
   localparam int SAMPLE_IRQ_NS      = 1000;
   localparam int SAMPLE_IRQ_CYCLES  = SAMPLE_IRQ_NS / CLK_PERIOD_NS;
   localparam int PACER_W            = 8;
   localparam int PULSE_W            = 5;

endpackage

// [event_path_if.sv]
// Purpose: Carries event levels, their rising edges and the sample tick.
// Assumes: All signals on the core clock.
// Notes:   Detector and pacer each take one modport; the core uses the whole interface.
`timescale 1ns/10ps
interface event_path_if;
   import event_irq_pkg::*;

   logic [EVENT_W-1:0] level;
   logic [EVENT_W-1:0] rise;
   logic               sample_tick;
   logic               sample_chan;

   modport detect (input level, output rise);
   modport pace   (output sample_tick, output sample_chan);
   modport core   (output level, input rise, input sample_tick, input sample_chan);
endinterface

// [sample_pacer.sv]
// Purpose: Paces new ADC samples at the sample rate, alternating channels.
// Assumes: Free running from reset release.
// Notes:   The tick is a one-cycle pulse; the channel flips on every tick.
`timescale 1ns/10ps
module sample_pacer #(
   parameter int PERIOD = event_irq_pkg::SAMPLE_CYCLES
) (
   input  wire logic  clk,
   input  wire logic  rstn,
   event_path_if.pace ev
);
   import event_irq_pkg::*;

   localparam int TICK_GAP = PERIOD;

   logic [PACER_W-1:0] count_q, count_d;
   logic               tick_q, tick_d;
   logic               chan_q, chan_d;

   // Counts one sample period and flips the channel at each wrap.
   always_comb begin
      tick_d  = 1'b0;
      chan_d  = chan_q;
      count_d = count_q + 1'b1;
      if (count_q == PACER_W'(PERIOD - 1)) begin
         count_d = '0;
         tick_d  = 1'b1;
         chan_d  = ~chan_q;
      end
   end

   // Registers the pacer state.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_q <= '0;
         tick_q  <= 1'b0;
         chan_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q  <= tick_d;
         chan_q  <= chan_d;
      end
   end

   assign ev.sample_tick = tick_q;
   assign ev.sample_chan = chan_q;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_tick_gap;
      tick_q |-> ##TICK_GAP tick_q;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Sample tick spacing wrong.");

   property p_chan_alternates;
      tick_q |-> (chan_q != $past(chan_q));
   endproperty
   a_chan_alternates: assert property (p_chan_alternates) else $error("Channel did not alternate.");
endmodule

// [rise_detector.sv]
// Purpose: Turns event levels into one-cycle rising edge pulses.
// Assumes: Levels come from logic on the same clock.
// Notes:   A level already high at reset release counts as a rise.
`timescale 1ns/10ps
module rise_detector (
   input  wire logic    clk,
   input  wire logic    rstn,
   event_path_if.detect ev
);
   import event_irq_pkg::*;

   logic [EVENT_W-1:0] prev_q, prev_d;
   logic [EVENT_W-1:0] rise_q, rise_d;

   // Compares each level with its value one cycle earlier.
   always_comb begin
      prev_d = ev.level;
      rise_d = ev.level & ~prev_q;
   end

   // Registers the history and the edge pulses.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         prev_q <= '0;
         rise_q <= '0;
      end else begin
         prev_q <= prev_d;
         rise_q <= rise_d;
      end
   end

   assign ev.rise = rise_q;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_rise_seen;
      $rose(ev.level[BIT_CH1_DOUT]) |=> ev.rise[BIT_CH1_DOUT];
   endproperty
   a_rise_seen: assert property (p_rise_seen) else $error("Output rise was missed.");
endmodule

// [host_model.sv]
// Purpose: Host processor model that reads and writes the unit's registers.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   A released bus shows the inverse of its last value.
`timescale 1ns/10ps
module host_model (
   input  wire logic                                clk,
   output logic [event_irq_pkg::ADDR_W-1:0]         reg_addr,
   output logic                                     reg_wr,
   output logic                                     reg_rd,
   output logic [event_irq_pkg::REG_W-1:0]          reg_wdata,
   input  wire logic [event_irq_pkg::REG_W-1:0]     reg_rdata,
   input  wire logic                                reg_rvalid
);
   import event_irq_pkg::*;

   // ==========================================================================
   // Bus idles quiet at time zero.
   initial begin
      reg_addr  = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = '0;
   end

   // One write: strobe for one edge, then release the bus.
   task automatic write_reg(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   // One read: the answer is taken at a falling edge, waiting a bounded time.
   task automatic read_reg(input logic [9:0] a, output logic [15:0] d, output logic ok);
      ok = 1'b0;
      d  = '0;
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      for (int i = 0; i < 3 && !ok; i++) begin
         @(negedge clk);
         if (reg_rvalid === 1'b1) begin
            d  = reg_rdata;
            ok = 1'b1;
         end
      end
   endtask

   // Acknowledge flags by writing ones at their positions.
   task automatic clear_flags(input logic [15:0] m);
      write_reg(LATCHED_OFFSET, m);
   endtask

   // Sample mode keeps every other mask bit at zero.
   task automatic sample_mode();
      write_reg(MASK_OFFSET, 16'h8000);
   endtask

   // A link fault that returns after its clear leads to reprogramming the mask.
   task automatic ack_link_fault(input logic [15:0] mask);
      logic [15:0] d;
      logic        ok;
      clear_flags(16'h0200);
      read_reg(LATCHED_OFFSET, d, ok);
      if (d[BIT_LINK_FAULT] === 1'b1) begin
         write_reg(MASK_OFFSET, mask);
      end
   endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the event flag and interrupt unit.
// Assumes: 20 MHz clock; short sample period of 40 cycles.
// Notes:   Outputs are sampled at falling edges, inputs change at rising ones.
`timescale 1ns/10ps
module testbench;
   import event_irq_pkg::*;

   localparam int SP = 40;

   logic        clk;
   logic        rstn;
   logic        reg_lock;
   logic [9:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [14:0] event_level;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        irq_n;
   logic        sample_strobe;
   logic        sample_chan;
   int          n_errors;
   int          checks;

   // ==========================================================================
   // Design and host.
   event_flag_interrupt_unit #(.SAMPLE_PERIOD(SP)) i_dut (.clk(clk), .rstn(rstn), .reg_lock(reg_lock),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .event_level(event_level),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_n(irq_n), .sample_strobe(sample_strobe),
      .sample_chan(sample_chan));
   host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // Clock generator.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================================================
   // Compare and helper tasks.
   task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp_bit(input string name, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic rd_check(input logic [9:0] a, input logic [15:0] exp, input string name);
      logic [15:0] d;
      logic        ok;
      i_host.read_reg(a, d, ok);
      cmp_bit({name, " answer"}, 1'b1, ok);
      cmp_word(name, exp, d);
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic set_level(input logic [14:0] v);
      @(posedge clk);
      event_level <= v;
   endtask

   task automatic set_lock(input logic v);
      @(posedge clk);
      reg_lock <= v;
   endtask

   // ==========================================================================
   // Scenarios.
   task automatic test_reset();
      rd_check(MASK_OFFSET, MASK_RESET, "mask");
      rd_check(LATCHED_OFFSET, LATCHED_RESET, "latched");
      cmp_bit("irq_n", 1'b1, irq_n);
      set_level(15'h4000);
      wait_cycles(4);
      cmp_bit("irq_n", 1'b0, irq_n);
      rd_check(LIVE_OFFSET, 16'h4000, "live");
      i_host.clear_flags(16'h4000);
      wait_cycles(2);
      cmp_bit("irq_n", 1'b1, irq_n);
      $display("test_reset done");
   endtask

   task automatic test_sources();
      logic [15:0] m;
      for (int b = 0; b < 14; b++) begin
         m = 16'h0001 << b;
         i_host.write_reg(MASK_OFFSET, m);
         set_level(15'h4000 | m[14:0]);
         wait_cycles(4);
         cmp_bit("irq_n", 1'b0, irq_n);
         set_level(15'h4000);
         i_host.write_reg(LATCHED_OFFSET, 16'h0000);
         rd_check(LATCHED_OFFSET, m, "flag");
         if (b == BIT_LINK_FAULT) begin
            i_host.ack_link_fault(m);
         end else begin
            i_host.clear_flags(m);
         end
         wait_cycles(2);
         cmp_bit("irq_n", 1'b1, irq_n);
         rd_check(LATCHED_OFFSET, 16'h0000, "cleared");
      end
      $display("test_sources done");
   endtask

   task automatic test_mask_lock();
      i_host.write_reg(MASK_OFFSET, 16'h0000);
      set_level(15'h4001);
      wait_cycles(4);
      cmp_bit("irq_n", 1'b1, irq_n);
      set_lock(1'b1);
      i_host.write_reg(MASK_OFFSET, 16'h0001);
      rd_check(MASK_OFFSET, 16'h0000, "locked mask");
      set_lock(1'b0);
      i_host.write_reg(MASK_OFFSET, 16'h0001);
      wait_cycles(2);
      cmp_bit("irq_n", 1'b0, irq_n);
      set_lock(1'b1);
      i_host.clear_flags(16'h0001);
      wait_cycles(2);
      cmp_bit("irq_n", 1'b1, irq_n);
      set_lock(1'b0);
      set_level(15'h4000);
      $display("test_mask_lock done");
   endtask

   task automatic test_live();
      set_level(15'h7ac5);
      wait_cycles(3);
      rd_check(LIVE_OFFSET, 16'h7ac5, "live");
      rd_check(LATCHED_OFFSET, 16'h3ac5, "latched");
      rd_check(10'h00e, 16'h0000, "unmapped");
      set_level(15'h4000);
      wait_cycles(2);
      rd_check(LIVE_OFFSET, 16'h4000, "live idle");
      rd_check(LATCHED_OFFSET, 16'h3ac5, "held");
      i_host.clear_flags(16'hffff);
      rd_check(LATCHED_OFFSET, 16'h0000, "all clear");
      $display("test_live done");
   endtask

   task automatic test_sample();
      int   cyc;
      int   low;
      logic ch;
      i_host.sample_mode();
      wait_cycles(2);
      cyc = 0;
      while (sample_strobe !== 1'b1 && cyc < 2 * SP) begin
         @(negedge clk);
         cyc++;
      end
      for (int k = 0; k < 2; k++) begin
         cmp_bit("strobe", 1'b1, sample_strobe);
         cmp_bit("sample irq_n", 1'b0, irq_n);
         ch  = sample_chan;
         cyc = 0;
         low = 0;
         do begin
            @(negedge clk);
            cyc++;
            if (irq_n === 1'b0) begin
               low++;
            end
         end while (sample_strobe !== 1'b1 && cyc < 2 * SP);
         cmp_word("period", 16'(SP), cyc[15:0]);
         cmp_word("irq width", 16'(SAMPLE_IRQ_CYCLES), low[15:0]);
         cmp_bit("channel", ~ch, sample_chan);
      end
      $display("test_sample done");
   endtask

   // ==========================================================================
   // Verdict and end of run.
   task automatic summarize();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: reset for four cycles, then every scenario in turn.
   initial begin
      n_errors    = 0;
      checks      = 0;
      rstn        = 1'b0;
      reg_lock    = 1'b0;
      event_level = '0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      test_reset();
      test_sources();
      test_mask_lock();
      test_live();
      test_sample();
      summarize();
   end
endmodule
